// File: ldc_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants and types for the segment display control bank.
// Assumes: Three 8-bit control registers reached by a 2-bit register index.
// Notes:   Every field position, mask and code used by the design lives here.
//------------------------------------------------------------------------------
package ldc_pkg;

   //---------------------------------------------------------------------------
   // Register indices.
   //---------------------------------------------------------------------------
   localparam logic [1:0] MAIN_IDX = 2'h0;
   localparam logic [1:0] CHG_IDX = 2'h1;
   localparam logic [1:0] DUTY_IDX = 2'h2;

   //---------------------------------------------------------------------------
   // Field positions.
   //---------------------------------------------------------------------------
   localparam int WAVE_BIT = 7;
   localparam int METHOD_BIT = 6;
   localparam int PUMP_HI = 5;
   localparam int PUMP_LO = 4;
   localparam int RES_HI = 3;
   localparam int RES_LO = 1;
   localparam int EN_BIT = 0;
   localparam int QCT_HI = 7;
   localparam int QCT_LO = 5;
   localparam int CHG_HOLE_BIT = 4;
   localparam int VA_TOP_BIT = 3;
   localparam int VA_LOW_HI = 2;
   localparam int VA_LOW_LO = 0;
   localparam int DUTY_HI = 2;
   localparam int DUTY_LO = 1;
   localparam int RATIO_BIT = 0;
   localparam int RES_CODE_TOP = 2;

   //---------------------------------------------------------------------------
   // Reset values and writable-bit masks.
   //---------------------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MAIN_MASK = 8'hff;
   localparam logic [7:0] CHG_MASK = 8'hef;
   localparam logic [7:0] DUTY_MASK = 8'h07;

   //---------------------------------------------------------------------------
   // Resistor field codes and level constants.
   //---------------------------------------------------------------------------
   localparam logic [2:0] RES_CODE_1170 = 3'h0;
   localparam logic [2:0] RES_CODE_225 = 3'h1;
   localparam logic [2:0] RES_CODE_60 = 3'h2;
   localparam logic [2:0] RES_CODE_QC_1170 = 3'h3;
   localparam logic [4:0] VA_BASE_NUM = 5'h08;
   localparam logic [4:0] VA_FULL_NUM = 5'h10;
   localparam int DIV_BITS = 3;
   localparam int QCT_BITS = 3;

   //---------------------------------------------------------------------------
   // Enumerations.
   //---------------------------------------------------------------------------
   typedef enum logic [1:0] {
      LDC_MODE_FAST = 2'b00,
      LDC_MODE_SLOW = 2'b01,
      LDC_MODE_IDLE = 2'b10,
      LDC_MODE_SLEEP = 2'b11
   } ldc_mode_type;

   typedef enum logic [1:0] {
      LDC_RES_1170K = 2'b00,
      LDC_RES_225K = 2'b01,
      LDC_RES_60K = 2'b10
   } ldc_res_type;

   typedef enum logic [1:0] {
      LDC_DUTY_QUARTER = 2'b00,
      LDC_DUTY_SIXTH = 2'b01,
      LDC_DUTY_EIGHTH = 2'b10
   } ldc_duty_type;

   localparam logic [7:0] COM_MASK_QUARTER = 8'h0f;
   localparam logic [7:0] COM_MASK_SIXTH = 8'h3f;
   localparam logic [7:0] COM_MASK_EIGHTH = 8'hff;

   // Commons in use for a duty code; the unimplemented code falls back to quarter duty.
   function automatic logic [7:0] com_mask(input logic [1:0] duty);
      logic [7:0] mask;
      mask = COM_MASK_QUARTER;
      case (duty)
         LDC_DUTY_SIXTH: mask = COM_MASK_SIXTH;
         LDC_DUTY_EIGHTH: mask = COM_MASK_EIGHTH;
         default: mask = COM_MASK_QUARTER;
      endcase
      return mask;
   endfunction

endpackage

// File: ldc_qc_if.sv
//------------------------------------------------------------------------------
// Purpose: Carries the quick-charge timing handshake between control and timer.
// Assumes: All signals belong to the single system clock domain.
// Notes:   phase_start and sub_tick are one-cycle pulses.
//------------------------------------------------------------------------------
interface ldc_qc_if;
   logic clk_en;
   logic sub_tick;
   logic phase_start;
   logic run;
   logic [ldc_pkg::QCT_BITS-1:0] len;
   logic fast_phase;

   modport ctrl (output clk_en, output sub_tick, output phase_start, output run,
                 output len, input fast_phase);
   modport timer (input clk_en, input sub_tick, input phase_start, input run,
                  input len, output fast_phase);
endinterface

// File: ldc_qc_timer.sv
//------------------------------------------------------------------------------
// Purpose: Times the low-resistance part of each common phase.
// Assumes: A phase start coincides with a sub-clock tick.
// Notes:   The interval is the length code plus one sub-clock periods.
//------------------------------------------------------------------------------
module ldc_qc_timer (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Timing handshake.
   ldc_qc_if.timer qc
);

   logic [ldc_pkg::QCT_BITS-1:0] tick_cnt;
   logic fast;
   logic at_end;

   // The interval ends on the tick that completes the programmed count.
   assign at_end = qc.sub_tick && (tick_cnt == qc.len);
   assign qc.fast_phase = fast;

   //---------------------------------------------------------------------------
   // Interval counter.
   //---------------------------------------------------------------------------
   // A new phase always restarts the interval, so a long code cannot spill over.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         fast <= 1'b0;
         tick_cnt <= '0;
      end
      else if (qc.clk_en)
      begin
         if (!qc.run)
         begin
            fast <= 1'b0;
            tick_cnt <= '0;
         end
         else if (qc.phase_start)
         begin
            fast <= 1'b1;
            tick_cnt <= '0;
         end
         else if (fast && qc.sub_tick)
         begin
            fast <= !at_end;
            tick_cnt <= tick_cnt + 1'b1;
         end
      end
   end

   //---------------------------------------------------------------------------
   // Checks.
   //---------------------------------------------------------------------------
   AST_QC_START: assert property (@(posedge clock) disable iff (!rst_b)
      qc.clk_en && qc.run && qc.phase_start |=> fast)
      else $error("Quick charge did not start at the phase boundary.");

   AST_QC_END: assert property (@(posedge clock) disable iff (!rst_b)
      qc.clk_en && qc.run && !qc.phase_start && fast && at_end |=> !fast)
      else $error("Quick charge outlasted its programmed interval.");

   AST_QC_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
      qc.clk_en && qc.run && !qc.phase_start && fast && !qc.sub_tick |=> fast)
      else $error("Quick charge ended between sub-clock ticks.");

endmodule

// File: ldc_ctrl_regs.sv
//------------------------------------------------------------------------------
// Purpose: Control register bank for the segment display driver.
// Assumes: The core reaches the three registers by index with a write strobe.
// Notes:   Analog bias and waveform generation sit outside; this block steers them.
//------------------------------------------------------------------------------
// Overview of operation
// - Enable acts only in fast, slow, idle.
// - Sleep mode always forces the display off.
// - Bit 7 picks waveform A or B.
// - Bit 6 picks resistor or charge-pump bias.
// - Two-bit field picks the charge-pump supply.
// - Codes 000-010 pick fixed bias resistance.
// - Codes 011 and 1xx pick quick-charge pairs.
// - Low resistance at each common phase start.
// - Charge interval is code plus one periods.
// - VA is (8+code)/16, top bit full.
// - Unimplemented bits always read back zero.
// - Duty field selects four, six or eight commons.
// - Ratio bit picks one-third or one-quarter bias.
// - Enable bit zero disables, one enables.
// - Unused commons are freed for shared pins.
// - Display clock is sub clock over eight.
// - Driver reset is disable OR sleep.
module ldc_ctrl_regs #(
   parameter int DIV_BITS = ldc_pkg::DIV_BITS
) (
   // Clock, reset and freeze.
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Chip operating mode and sub clock pin.
   input wire logic [1:0] op_mode,
   input wire logic sub_clock,
   // Register port.
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Bias and waveform selections.
   output logic wave_b,
   output logic cap_bias,
   output logic [1:0] pump_source,
   output logic [1:0] res_setting,
   output logic quick_mode,
   output logic fast_charge_on,
   output logic [4:0] va_sixteenths,
   output logic [1:0] duty_sel,
   output logic quarter_bias,
   // Commons and driver state.
   output logic [7:0] com_used,
   output logic [7:0] com_free,
   output logic display_on,
   output logic display_reset,
   output logic display_tick
);

   localparam logic [DIV_BITS-1:0] DIV_LAST = {DIV_BITS{1'b1}};

   //---------------------------------------------------------------------------
   // Registers and internal state.
   //---------------------------------------------------------------------------
   logic [7:0] display_main_control;
   logic [7:0] display_charge_and_level;
   logic [7:0] display_duty_and_ratio;
   logic sub_sync1;
   logic sub_sync2;
   logic sub_last;
   logic [DIV_BITS-1:0] div_cnt;

   ldc_qc_if qc ();

   //---------------------------------------------------------------------------
   // Field extraction.
   //---------------------------------------------------------------------------
   logic panel_on;
   logic [2:0] bias_resistance_sel;
   logic [2:0] fast_charge_len;
   logic [3:0] va_ratio_sel;
   logic [1:0] duty_field;
   logic sleeping;
   logic run_mode;

   // Fields are read straight from the stored registers.
   assign panel_on = display_main_control[ldc_pkg::EN_BIT];
   assign bias_resistance_sel = display_main_control[ldc_pkg::RES_HI:ldc_pkg::RES_LO];
   assign fast_charge_len = display_charge_and_level[ldc_pkg::QCT_HI:ldc_pkg::QCT_LO];
   assign va_ratio_sel = display_charge_and_level[ldc_pkg::VA_TOP_BIT:ldc_pkg::VA_LOW_LO];
   assign duty_field = display_duty_and_ratio[ldc_pkg::DUTY_HI:ldc_pkg::DUTY_LO];
   assign sleeping = (op_mode == ldc_pkg::LDC_MODE_SLEEP);
   assign run_mode = !sleeping;

   //---------------------------------------------------------------------------
   // Register write decode.
   //---------------------------------------------------------------------------
   logic wr_main;
   logic wr_chg;
   logic wr_duty;

   // An index with no register behind it is simply not written.
   assign wr_main = reg_wr && (reg_addr == ldc_pkg::MAIN_IDX);
   assign wr_chg = reg_wr && (reg_addr == ldc_pkg::CHG_IDX);
   assign wr_duty = reg_wr && (reg_addr == ldc_pkg::DUTY_IDX);

   // Writes are masked so that holes in the map never store anything.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         display_main_control <= ldc_pkg::REG_RESET;
         display_charge_and_level <= ldc_pkg::REG_RESET;
         display_duty_and_ratio <= ldc_pkg::REG_RESET;
      end
      else if (clk_en)
      begin
         if (wr_main)
            display_main_control <= reg_wdata & ldc_pkg::MAIN_MASK;
         if (wr_chg)
            display_charge_and_level <= reg_wdata & ldc_pkg::CHG_MASK;
         if (wr_duty)
            display_duty_and_ratio <= reg_wdata & ldc_pkg::DUTY_MASK;
      end
   end

   //---------------------------------------------------------------------------
   // Read data.
   //---------------------------------------------------------------------------
   logic [7:0] next_reg_rdata;

   // Read data follows the index one cycle later; the spare index reads zero.
   assign next_reg_rdata =
      (reg_addr == ldc_pkg::MAIN_IDX) ? display_main_control :
      (reg_addr == ldc_pkg::CHG_IDX) ? display_charge_and_level :
      (reg_addr == ldc_pkg::DUTY_IDX) ? display_duty_and_ratio :
      ldc_pkg::REG_RESET;

   //---------------------------------------------------------------------------
   // Sub clock synchroniser and display clock divider.
   //---------------------------------------------------------------------------
   logic sub_rise;
   logic next_display_on;
   logic next_tick;

   // The sub clock is a pin, so it passes two flops before the edge detector.
   assign sub_rise = sub_sync2 && !sub_last;
   assign next_display_on = panel_on && run_mode;
   assign next_tick = sub_rise && display_on && (div_cnt == DIV_LAST);

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         sub_sync1 <= 1'b0;
         sub_sync2 <= 1'b0;
         sub_last <= 1'b0;
      end
      else if (clk_en)
      begin
         sub_sync1 <= sub_clock;
         sub_sync2 <= sub_sync1;
         sub_last <= sub_sync2;
      end
   end

   // The divider is held cleared while the driver is in reset, so a restart is clean.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         div_cnt <= '0;
      else if (clk_en)
      begin
         if (!display_on)
            div_cnt <= '0;
         else if (sub_rise)
            div_cnt <= div_cnt + 1'b1;
      end
   end

   //---------------------------------------------------------------------------
   // Quick-charge timer hookup.
   //---------------------------------------------------------------------------
   logic next_quick;

   // Quick charge runs only for codes 011 and 1xx while the driver runs.
   assign next_quick = (bias_resistance_sel == ldc_pkg::RES_CODE_QC_1170) ||
                       bias_resistance_sel[ldc_pkg::RES_CODE_TOP];
   assign qc.clk_en = clk_en;
   assign qc.sub_tick = sub_rise;
   assign qc.phase_start = next_tick;
   assign qc.run = display_on && next_quick;
   assign qc.len = fast_charge_len;

   ldc_qc_timer u_qc_timer (
      .clock(clock),
      .rst_b(rst_b),
      .qc(qc.timer)
   );

   //---------------------------------------------------------------------------
   // Resistance and level decode.
   //---------------------------------------------------------------------------
   logic [1:0] next_res_setting;
   logic [4:0] next_va;
   logic fast_now;

   // During the fast part of a phase the low resistance always applies.
   assign fast_now = qc.fast_phase && next_quick;
   assign next_res_setting =
      fast_now ? ldc_pkg::LDC_RES_60K :
      (bias_resistance_sel == ldc_pkg::RES_CODE_60) ? ldc_pkg::LDC_RES_60K :
      (bias_resistance_sel == ldc_pkg::RES_CODE_225) ? ldc_pkg::LDC_RES_225K :
      bias_resistance_sel[ldc_pkg::RES_CODE_TOP] ? ldc_pkg::LDC_RES_225K :
      ldc_pkg::LDC_RES_1170K;

   assign next_va = va_ratio_sel[ldc_pkg::VA_TOP_BIT] ? ldc_pkg::VA_FULL_NUM :
      ldc_pkg::VA_BASE_NUM + {2'h0, va_ratio_sel[ldc_pkg::VA_LOW_HI:ldc_pkg::VA_LOW_LO]};

   //---------------------------------------------------------------------------
   // Output flops.
   //---------------------------------------------------------------------------
   // Every output is registered so the analog side never sees decode glitches.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         reg_rdata <= ldc_pkg::REG_RESET;
         wave_b <= 1'b0;
         cap_bias <= 1'b0;
         pump_source <= 2'h0;
         res_setting <= ldc_pkg::LDC_RES_1170K;
         quick_mode <= 1'b0;
         fast_charge_on <= 1'b0;
         va_sixteenths <= ldc_pkg::VA_BASE_NUM;
         duty_sel <= ldc_pkg::LDC_DUTY_QUARTER;
         quarter_bias <= 1'b0;
         com_used <= ldc_pkg::COM_MASK_QUARTER;
         com_free <= ~ldc_pkg::COM_MASK_QUARTER;
         display_on <= 1'b0;
         display_reset <= 1'b1;
         display_tick <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata <= next_reg_rdata;
         wave_b <= display_main_control[ldc_pkg::WAVE_BIT];
         cap_bias <= display_main_control[ldc_pkg::METHOD_BIT];
         pump_source <= display_main_control[ldc_pkg::PUMP_HI:ldc_pkg::PUMP_LO];
         res_setting <= next_res_setting;
         quick_mode <= next_quick;
         fast_charge_on <= fast_now;
         va_sixteenths <= next_va;
         duty_sel <= duty_field;
         quarter_bias <= display_duty_and_ratio[ldc_pkg::RATIO_BIT];
         com_used <= ldc_pkg::com_mask(duty_field);
         com_free <= ~ldc_pkg::com_mask(duty_field);
         display_on <= next_display_on;
         display_reset <= !next_display_on;
         display_tick <= next_tick;
      end
   end

   //---------------------------------------------------------------------------
   // Checks.
   //---------------------------------------------------------------------------
   AST_SLEEP_OFF: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && sleeping |=> !display_on && display_reset)
      else $error("Display stayed on in sleep mode.");

   AST_ENABLE_RUN: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && run_mode && panel_on |=> display_on && !display_reset)
      else $error("Enabled display not running in an active mode.");

   AST_WAVE_WRITE: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && wr_main ##1 clk_en |=> wave_b == $past(reg_wdata[ldc_pkg::WAVE_BIT], 2))
      else $error("Waveform select does not follow the written bit.");

   AST_HOLE_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && reg_addr == ldc_pkg::CHG_IDX |=> !reg_rdata[ldc_pkg::CHG_HOLE_BIT])
      else $error("Unimplemented charge register bit read as one.");

   AST_DUTY_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && reg_addr == ldc_pkg::DUTY_IDX |=> reg_rdata[7:3] == 5'h00)
      else $error("Unimplemented duty register bits read as one.");

   AST_VA_FULL: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && va_ratio_sel[ldc_pkg::VA_TOP_BIT] |=> va_sixteenths == ldc_pkg::VA_FULL_NUM)
      else $error("VA top code did not select the full supply.");

   AST_FREE_COMS: assert property (@(posedge clock) disable iff (!rst_b)
      com_free == ~com_used)
      else $error("Freed commons overlap the commons in use.");

   AST_DIV_TICK: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && sub_rise && display_on && div_cnt == DIV_LAST |=> display_tick)
      else $error("Display clock did not tick on the eighth sub-clock edge.");

   AST_FAST_LOW_R: assert property (@(posedge clock) disable iff (!rst_b)
      fast_charge_on |-> res_setting == ldc_pkg::LDC_RES_60K && quick_mode)
      else $error("Quick charge not at low resistance.");

   AST_FIXED_R: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && bias_resistance_sel == ldc_pkg::RES_CODE_225 |=> res_setting == ldc_pkg::LDC_RES_225K)
      else $error("Fixed resistance code not honoured.");

   AST_RESET_OR: assert property (@(posedge clock) disable iff (!rst_b)
      display_reset == !display_on)
      else $error("Driver reset is not the inverse of display on.");

   AST_METHOD_SEL: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en |=> cap_bias == $past(display_main_control[ldc_pkg::METHOD_BIT]))
      else $error("Bias method does not follow its bit.");

   AST_PUMP_SEL: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en |=> pump_source == $past(display_main_control[ldc_pkg::PUMP_HI:ldc_pkg::PUMP_LO]))
      else $error("Pump source does not follow its field.");

   AST_DUTY_COMS: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en |=> com_used == ldc_pkg::com_mask($past(duty_field)))
      else $error("Commons in use do not match the duty field.");

   AST_RATIO_SEL: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en |=> quarter_bias == $past(display_duty_and_ratio[ldc_pkg::RATIO_BIT]))
      else $error("Bias ratio does not follow its bit.");

   AST_QUICK_SLOW: assert property (@(posedge clock) disable iff (!rst_b)
      clk_en && bias_resistance_sel[ldc_pkg::RES_CODE_TOP] && !fast_now |=>
         res_setting == ldc_pkg::LDC_RES_225K)
      else $error("Quick charge rest phase not at the middle resistance.");

endmodule

// File: ldc_sub_src.sv
//------------------------------------------------------------------------------
// Purpose: Sub clock source standing in for the oscillator beside the block.
// Assumes: The half period is unrelated to the 40 ns system clock.
// Notes:   The clock stands still low while run is low.
//------------------------------------------------------------------------------
module ldc_sub_src #(
   parameter int HALF_NS = 203
) (
   // Control.
   input wire logic run,
   // Sub clock pin.
   output logic sub_clock
);
   timeunit 1ns;
   timeprecision 1ns;

   // Toggle only while running, so no stray edges reach the divider when idle.
   initial sub_clock = 1'b0;
   always
   begin
      #HALF_NS;
      if (run)
         sub_clock = ~sub_clock;
      else
         sub_clock = 1'b0;
   end
endmodule

// File: ldc_tb.sv
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for the display control register bank.
// Assumes: Sub clock period of 406 ns, about 10.15 system clock cycles.
// Notes:   Timing figures tied to the sub clock use a small tolerance.
//------------------------------------------------------------------------------
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, sub_run = 1'b0;
   logic [1:0] op_mode = 2'h0, reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic sub_clock, wave_b, cap_bias, quick_mode, fast_charge_on, quarter_bias;
   logic display_on, display_reset, display_tick;
   logic [7:0] reg_rdata, com_used, com_free;
   logic [1:0] pump_source, res_setting, duty_sel;
   logic [4:0] va_sixteenths;
   int failures = 0, samples_checked = 0, cyc = 0;

   ldc_sub_src sub (.run(sub_run), .sub_clock(sub_clock));
   ldc_ctrl_regs uut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .op_mode(op_mode),
      .sub_clock(sub_clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .wave_b(wave_b), .cap_bias(cap_bias),
      .pump_source(pump_source), .res_setting(res_setting), .quick_mode(quick_mode),
      .fast_charge_on(fast_charge_on), .va_sixteenths(va_sixteenths), .duty_sel(duty_sel),
      .quarter_bias(quarter_bias), .com_used(com_used), .com_free(com_free),
      .display_on(display_on), .display_reset(display_reset), .display_tick(display_tick));

   // Free-running clock and cycle count used for interval measurement.
   always #20 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;

   //---------------------------------------------------------------------------
   // Shared tasks.
   //---------------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One write strobe, then two edges so outputs and read data have settled.
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask

   task automatic rd(input logic [1:0] a);
      @(posedge clock);
      reg_addr <= a;
      repeat (2) @(posedge clock);
      #1;
   endtask

   // Bounded wait for the next phase boundary pulse.
   task automatic wait_tick();
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         n++;
      end
      while (display_tick !== 1'b1 && n < 400);
      chk(8'(n < 400), 8'h01, "phase tick missing");
   endtask

   //---------------------------------------------------------------------------
   // Scenarios.
   //---------------------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 4; i++)
      begin
         rd(2'(i));
         chk(reg_rdata, 8'h00, "reset value");
      end
      chk(8'(va_sixteenths), 8'h08, "reset level");
      chk(com_free, 8'hf0, "reset commons");
      chk(8'(display_reset), 8'h01, "reset driver");
      wr(2'h3, 8'hff);
      chk(reg_rdata, 8'h00, "unmapped index");
   endtask

   // Every pump and resistor code with the panel off, so no fast interval runs.
   task automatic t_main();
      logic [1:0] er;
      for (int i = 0; i < 8; i++)
      begin
         wr(ldc_pkg::MAIN_IDX, {i[0], i[1], i[1:0], i[2:0], 1'b0});
         chk(reg_rdata, {i[0], i[1], i[1:0], i[2:0], 1'b0}, "main readback");
         chk(8'(wave_b), 8'(i[0]), "waveform");
         chk(8'(cap_bias), 8'(i[1]), "bias method");
         chk(8'(pump_source), 8'(i[1:0]), "pump source");
         er = (i < 3) ? 2'(i) : ((i == 3) ? 2'h0 : 2'h1);
         chk(8'(res_setting), 8'(er), "resistance");
         chk(8'(quick_mode), 8'(i >= 3), "quick mode");
      end
   endtask

   task automatic t_chg_duty();
      logic [7:0] cm;
      wr(ldc_pkg::CHG_IDX, 8'hff);
      chk(reg_rdata, 8'hef, "charge hole");
      wr(ldc_pkg::DUTY_IDX, 8'hff);
      chk(reg_rdata, 8'h07, "duty holes");
      for (int i = 0; i < 16; i++)
      begin
         wr(ldc_pkg::CHG_IDX, 8'(i));
         chk(8'(va_sixteenths), (i > 7) ? 8'h10 : 8'(8 + i), "level ratio");
      end
      for (int i = 0; i < 8; i++)
      begin
         wr(ldc_pkg::DUTY_IDX, 8'(i));
         cm = (i[2:1] == 2'h1) ? 8'h3f : ((i[2:1] == 2'h2) ? 8'hff : 8'h0f);
         chk(com_used, cm, "commons used");
         chk(com_free, ~cm, "commons freed");
         chk(8'(duty_sel), 8'(i[2:1]), "duty");
         chk(8'(quarter_bias), 8'(i[0]), "bias ratio");
      end
      wr(ldc_pkg::DUTY_IDX, 8'h05);
      chk(com_used, 8'hff, "eighth duty");
      chk(8'(quarter_bias), 8'h01, "quarter bias");
   endtask

   task automatic t_modes();
      wr(ldc_pkg::MAIN_IDX, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clock);
         op_mode <= 2'(m);
         repeat (3) @(posedge clock);
         #1;
         chk(8'(display_on), 8'(m != 3), "mode gating");
         chk(8'(display_reset), 8'(m == 3), "driver reset");
      end
      @(posedge clock);
      op_mode <= 2'h0;
      wr(ldc_pkg::MAIN_IDX, 8'h00);
      chk(8'(display_on), 8'h00, "enable clear");
      @(posedge clock);
      clk_en <= 1'b0;
      wr(ldc_pkg::MAIN_IDX, 8'h81);
      chk(8'(display_on), 8'h00, "frozen enable");
      @(posedge clock);
      clk_en <= 1'b1;
      rd(ldc_pkg::MAIN_IDX);
      chk(reg_rdata, 8'h00, "frozen write");
   endtask

   // Code 011 with a three-period interval; one sub period is about 10.15 cycles.
   task automatic t_quick();
      int t0;
      wr(ldc_pkg::CHG_IDX, 8'h40);
      wr(ldc_pkg::MAIN_IDX, 8'h07);
      sub_run <= 1'b1;
      wait_tick();
      t0 = cyc;
      repeat (2) @(posedge clock);
      #1;
      chk(8'(fast_charge_on), 8'h01, "fast start");
      chk(8'(res_setting), 8'h02, "fast resistance");
      for (int n = 0; n < 100 && fast_charge_on === 1'b1; n++)
      begin
         @(posedge clock);
         #1;
      end
      #1;
      chk(8'(cyc - t0 >= 28 && cyc - t0 <= 34), 8'h01, "fast length");
      repeat (2) @(posedge clock);
      #1;
      chk(8'(res_setting), 8'h00, "slow resistance");
      wait_tick();
      chk(8'(cyc - t0 >= 79 && cyc - t0 <= 84), 8'h01, "phase length");
      sub_run <= 1'b0;
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence and a watchdog well past the expected few hundred cycles.
   initial
   begin
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_main();
      t_chg_duty();
      t_modes();
      t_quick();
      conclude();
   end

   initial
   begin
      #400000;
      failures++;
      conclude();
   end
endmodule
